// ===== testbench.sv
// self-checking bench of the wake-up and interrupt mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        ref_clk, reset_n;            // clock and async reset
	logic [3:0]  avs_address;                 // bus word index
	logic        avs_read, avs_write;         // bus strobes
	logic [31:0] avs_writedata, avs_readdata; // bus data
	logic        avs_waitrequest;             // bus stall
	logic [8:0]  event_in;                    // event pulses
	logic        wdt_timeout, lowvolt_reset;  // reset sources
	logic        adc_busy, resume_ack;        // adc level, core ack
	logic        osc_run, timers_run;         // clock gating levels
	logic        slow_clock_run, main_clock_run;
	logic        wdt_clear, core_wake, core_vector_req;
	logic [7:0]  core_vector;                 // vector to the core
	logic        core_next_instr, device_reset, irq;
	int          err_total, checks;           // verdict counters
	int          n_wake, n_next, n_rst, n_clr; // pulse counts
	logic        vseen;                       // vector request seen
	logic [7:0]  vec_val;                     // vector seen with it
	logic [31:0] seed, q;                     // random state, read data
	logic [2:0]  dly;                         // core ack delay
	wkm_ctrl wkm_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.event_in(event_in), .wdt_timeout(wdt_timeout),
		.lowvolt_reset(lowvolt_reset), .adc_busy(adc_busy),
		.resume_ack(resume_ack), .osc_run(osc_run),
		.timers_run(timers_run), .slow_clock_run(slow_clock_run),
		.main_clock_run(main_clock_run), .wdt_clear(wdt_clear),
		.core_wake(core_wake), .core_vector_req(core_vector_req),
		.core_vector(core_vector), .core_next_instr(core_next_instr),
		.device_reset(device_reset), .irq(irq));
	wkm_core_model wkm_core_model_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.core_vector_req(core_vector_req), .delay(dly),
		.resume_ack(resume_ack));
	// free running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// counts the core-side pulses since the last reset
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			n_wake = 0;
			n_next = 0;
			n_rst = 0;
			n_clr = 0;
			vseen = 1'b0;
			vec_val = 8'h00;
		end else begin
			if (core_wake === 1'b1) n_wake++;
			if (core_next_instr === 1'b1) n_next++;
			if (device_reset === 1'b1) n_rst++;
			if (wdt_clear === 1'b1) n_clr++;
			if (core_vector_req === 1'b1) begin
				vseen = 1'b1;
				vec_val = core_vector;
			end
		end
	end
	// compares and reports one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 20) err_total++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask
	// reset held for two cycles
	task rst;
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask
	// xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// whether an event wakes the core in a given mode
	function automatic logic wakes(input logic [1:0] m, input logic [3:0] wk,
		input int ev);
		if (!m[1]) return 1'b0;
		case (ev)
			0: return wk[1];
			1: return wk[3];
			2: return wk[2];
			default: return m == 2'h2;
		endcase
	endfunction
	// vector of each event source
	function automatic logic [7:0] vec_of(input int ev);
		case (ev)
			0: return 8'h06;
			1: return 8'h0C;
			2: return 8'h21;
			default: return 8'h09;
		endcase
	endfunction
	// one event in one mode with one enable setting
	task sc(input logic [1:0] m, input logic [3:0] wk, input logic [8:0] mk,
		input logic gie, input int ev);
		logic w, v;
		w = wakes(m, wk, ev);
		rst;
		bus(1'b1, 4'h0, {30'h0, m == 2'h1, m == 2'h2});
		bus(1'b1, 4'h1, {28'h0, wk});
		bus(1'b1, 4'h2, {23'h0, mk});
		if (gie) bus(1'b1, 4'h6, 32'h2);
		if (m[1]) bus(1'b1, 4'h6, 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk(q[1:0], m);
		chk(timers_run, m != 2'h3);
		chk(osc_run, m != 2'h3);
		chk(n_clr, m[1]);
		@(posedge ref_clk);
		event_in <= 9'h1 << ev;
		adc_busy <= ev == 1;
		@(posedge ref_clk);
		event_in <= 9'h0;
		@(negedge ref_clk);
		if (ev == 1) chk({slow_clock_run, main_clock_run}, 2'h3);
		repeat (10) @(posedge ref_clk);
		adc_busy <= 1'b0;
		chk(n_wake, w);
		v = gie && mk[ev] && (w || !m[1]);
		if (m[1]) chk(n_next, w && !(gie && mk[ev]));
		chk(vseen, v);
		if (v) chk(vec_val, vec_of(ev));
		bus(1'b0, 4'h3, 32'h0);
		chk(q[ev], mk[ev]);
		chk(irq, mk[ev]);
		bus(1'b1, 4'h3, 32'h1 << ev);
		bus(1'b0, 4'h3, 32'h0);
		chk(q, 32'h0);
		chk(irq, 1'b0);
	endtask
	// watchdog or low-voltage reset request in one mode
	task rs(input logic [1:0] m, input logic wen, input logic lv,
		input logic e);
		rst;
		bus(1'b1, 4'h0, {29'h0, wen, m == 2'h1, m == 2'h2});
		if (m[1]) bus(1'b1, 4'h6, 32'h1);
		@(posedge ref_clk);
		wdt_timeout <= !lv;
		lowvolt_reset <= lv;
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		lowvolt_reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(n_rst, e);
	endtask
	// prints the verdict and ends the run
	task test_done;
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence: corners, then random settings in every mode
	initial begin
		{reset_n, avs_read, avs_write, adc_busy} = 4'h0;
		{wdt_timeout, lowvolt_reset, avs_address} = 6'h00;
		{avs_writedata, event_in, dly} = 44'h0;
		{err_total, checks} = 0;
		seed = 32'h6abb919d;
		rst;
		bus(1'b0, 4'h4, 32'h0);
		chk(q, 32'h0);
		for (int a = 7; a < 16; a++) begin
			bus(1'b1, a[3:0], seed);
			bus(1'b0, a[3:0], 32'h0);
			chk(q, 32'h0);
		end
		sc(2'h3, 4'h0, 9'h001, 1'b1, 0);
		sc(2'h2, 4'h2, 9'h000, 1'b0, 0);
		sc(2'h3, 4'hE, 9'h1FF, 1'b1, 5);
		for (int r = 0; r < 2; r++)
			for (int m = 0; m < 4; m++)
				for (int ev = 0; ev < 9; ev++) begin
					seed = xs(seed);
					dly <= seed[2:0];
					sc(m[1:0], seed[6:3], seed[15:7], seed[16], ev);
				end
		rs(2'h0, 1'b1, 1'b0, 1'b1);
		rs(2'h0, 1'b0, 1'b0, 1'b0);
		rs(2'h1, 1'b0, 1'b1, 1'b1);
		rs(2'h3, 1'b0, 1'b1, 1'b0);
		rs(2'h3, 1'b1, 1'b0, 1'b1);
		test_done;
	end
	// cuts a hang short
	initial begin
		repeat (50000) @(posedge ref_clk);
		err_total++;
		test_done;
	end
endmodule
`default_nettype wire

// ===== wkm_core_model.sv
// core sequencer model that acknowledges vector requests
`timescale 1ns/1ps
`default_nettype none
module wkm_core_model (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       core_vector_req,
	input  wire logic [2:0] delay,
	output logic            resume_ack
);
	logic [2:0] cnt_reg;  // cycles the request has waited
	logic       done_reg; // ack already given for this request
	// one ack per request, after a prompt or slow wait
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 3'h0;
			done_reg <= 1'b0;
			resume_ack <= 1'b0;
		end else begin
			resume_ack <= core_vector_req && !done_reg && cnt_reg == delay;
			done_reg <= core_vector_req && (done_reg || cnt_reg == delay);
			cnt_reg <= (core_vector_req && !done_reg) ? cnt_reg + 3'h1 : 3'h0;
		end
	end
endmodule
`default_nettype wire

// ===== wkm_ctrl.sv
// wake-up and interrupt mode controller with avalon-mm registers
`include "wkm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module wkm_ctrl #(
	parameter int NEV = `WKM_NUM_EV
) (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [NEV-1:0] event_in,
	input  wire logic        wdt_timeout,
	input  wire logic        lowvolt_reset,
	input  wire logic        adc_busy,
	input  wire logic        resume_ack,
	output logic             osc_run,
	output logic             timers_run,
	output logic             slow_clock_run,
	output logic             main_clock_run,
	output logic             wdt_clear,
	output logic             core_wake,
	output logic             core_vector_req,
	output logic      [7:0]  core_vector,
	output logic             core_next_instr,
	output logic             device_reset,
	output logic             irq
);
	initial begin
		if (NEV != `WKM_NUM_EV) $error("wkm_ctrl: NEV must be 9");
	end

	// registers
	logic [2:0]     ctrl_reg, ctrl_next;   // idle/green/wdt enables
	logic [3:0]     wake_reg, wake_next;   // wake enables
	logic [NEV-1:0] mask_reg, mask_next;   // irq enables
	logic [NEV-1:0] flag_reg, flag_next;   // sticky pending flags
	logic           gie_reg,  gie_next;    // global irq enable
	wkm_pkg::wkm_mode_type mode_reg, mode_next;
	logic [7:0]     vec_reg, vec_next;     // vector output
	logic           wake_p_reg, wake_p_next;
	logic           vreq_reg, vreq_next;
	logic           next_reg, next_next;
	logic           rst_reg, rst_next;
	logic           wclr_reg, wclr_next;
	logic [31:0]    rd_reg, rd_next;
	logic           ack_reg, ack_next;     // one-cycle wait then answer

	logic [NEV-1:0] wake_ok;               // event may wake current mode
	logic [3:0]     pick_idx;
	logic           pick_any;
	logic [NEV-1:0] pend_irq;
	logic           asleep;
	logic           run_mode;
	logic           req;
	logic [NEV-1:0] clr_bits;              // flags cleared by a write
	logic [NEV-1:0] pend_next;             // enabled and pending next

	assign asleep   = (mode_reg == wkm_pkg::WKM_SLEEP) ||
			(mode_reg == wkm_pkg::WKM_IDLE);
	assign run_mode = !asleep;
	assign req      = (avs_read || avs_write) && !ack_reg;

	// per-source wake qualification
	always_comb begin
		wake_ok = '0;
		// port change needs its wake enable
		wake_ok[`WKM_EV_PORT] = wake_reg[`WKM_WAKE_PORT];
		// adc done needs its wake enable
		wake_ok[`WKM_EV_ADC]  = wake_reg[`WKM_WAKE_ADC];
		// low voltage needs its wake enable
		wake_ok[`WKM_EV_LVD]  = wake_reg[`WKM_WAKE_LVD];
		// timers wake from idle, never from sleep
		for (int i = `WKM_EV_MAIN_TMR; i < NEV; i++)
			wake_ok[i] = (mode_reg == wkm_pkg::WKM_IDLE);
	end

	assign pend_irq = flag_reg & mask_reg;

	// flag update: a written one clears, a new event with its irq enable sets
	always_comb begin
		clr_bits = '0;
		// clears land with the write, at the edge that ends the wait
		if (avs_write && ack_reg && avs_address == `WKM_ADDR_FLAG)
			clr_bits = avs_writedata[NEV-1:0];
		// flags: set wins over clear
		flag_next = (flag_reg & ~clr_bits) | (event_in & mask_reg);
	end

	// enabled sources that stand pending after this edge
	assign pend_next = flag_next & mask_reg;

	// picks from next flags, so an event in this cycle competes too
	wkm_prio #(.N(NEV)) u_prio (
		.req (pend_next),
		.idx (pick_idx),
		.any (pick_any)
	);

	// vector lookup per source
	function automatic logic [7:0] vec_of(input logic [3:0] k);
		case (k)
			4'h0:    vec_of = `WKM_VEC_PORT;
			4'h1:    vec_of = `WKM_VEC_ADC;
			4'h2:    vec_of = `WKM_VEC_LVD;
			default: vec_of = `WKM_VEC_TIMER;
		endcase
	endfunction

	// next state of mode, enables and core handshake
	always_comb begin
		logic           woke;
		woke      = 1'b0;
		ctrl_next = ctrl_reg;
		wake_next = wake_reg;
		mask_next = mask_reg;
		gie_next  = gie_reg;
		mode_next = mode_reg;
		vec_next  = vec_reg;
		wake_p_next = 1'b0;
		vreq_next = vreq_reg && !resume_ack;
		next_next = 1'b0;
		rst_next  = 1'b0;
		wclr_next = 1'b0;
		rd_next   = rd_reg;
		ack_next  = req;
		// register writes land at the edge that ends the wait
		if (avs_write && ack_reg) begin
			case (avs_address)
				`WKM_ADDR_CTRL: ctrl_next = avs_writedata[2:0];
				`WKM_ADDR_WAKE: wake_next = avs_writedata[3:0];
				`WKM_ADDR_MASK: mask_next = avs_writedata[NEV-1:0];
				`WKM_ADDR_FLAG: ;   // cleared in the flag update
				`WKM_ADDR_CMD: begin
					if (avs_writedata[`WKM_CMD_GIE_ON])  gie_next = 1'b1;
					if (avs_writedata[`WKM_CMD_GIE_OFF]) gie_next = 1'b0;
					if (avs_writedata[`WKM_CMD_SLEEP] && run_mode) begin
						// sleep instr enters idle or sleep
						mode_next = ctrl_reg[`WKM_CTRL_IDLE] ?
							wkm_pkg::WKM_IDLE : wkm_pkg::WKM_SLEEP;
						wclr_next = 1'b1;   // watchdog cleared
					end
				end
				default: ;
			endcase
		end
		// green and normal follow the control bit while running
		if (run_mode && mode_next == mode_reg)
			mode_next = ctrl_next[`WKM_CTRL_GREEN] ?
				wkm_pkg::WKM_GREEN : wkm_pkg::WKM_NORMAL;
		// wake only from sleep or idle
		if (asleep && |(event_in & wake_ok)) begin
			woke        = 1'b1;
			wake_p_next = 1'b1;
			mode_next   = ctrl_reg[`WKM_CTRL_GREEN] ?
				wkm_pkg::WKM_GREEN : wkm_pkg::WKM_NORMAL;
		end
		// vector or next instruction after wake or in run
		if (woke && !(gie_reg && pick_any))
			next_next = 1'b1;
		else if ((woke || run_mode) && gie_reg && !vreq_reg &&
				pick_any) begin
			// lowest pending source, new events included
			vreq_next = 1'b1;
			vec_next  = vec_of(pick_idx);
		end
		// watchdog and low voltage reset override mode, vector request and next instruction
		if ((wdt_timeout && ctrl_reg[`WKM_CTRL_WDT_EN]) ||
				(lowvolt_reset && run_mode)) begin
			rst_next  = 1'b1;
			mode_next = wkm_pkg::WKM_NORMAL;
			vreq_next = 1'b0;
			next_next = 1'b0;
		end
		// register read mux
		if (avs_read && req) begin
			case (avs_address)
				`WKM_ADDR_CTRL:   rd_next = {29'h0, ctrl_reg};
				`WKM_ADDR_WAKE:   rd_next = {28'h0, wake_reg};
				`WKM_ADDR_MASK:   rd_next = {23'h0, mask_reg};
				`WKM_ADDR_FLAG:   rd_next = {23'h0, flag_reg};
				`WKM_ADDR_STATE:  rd_next = {27'h0, gie_reg, vreq_reg,
					asleep, 2'(mode_reg)};
				`WKM_ADDR_VECTOR: rd_next = {24'h0, vec_reg};
				default:          rd_next = 32'h0000_0000;
			endcase
		end
	end

	// register all state
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg   <= '0;
			wake_reg   <= '0;
			mask_reg   <= '0;
			flag_reg   <= '0;
			gie_reg    <= 1'b0;
			mode_reg   <= wkm_pkg::WKM_NORMAL;
			vec_reg    <= 8'h00;
			wake_p_reg <= 1'b0;
			vreq_reg   <= 1'b0;
			next_reg   <= 1'b0;
			rst_reg    <= 1'b0;
			wclr_reg   <= 1'b0;
			rd_reg     <= `WKM_RESET_VAL;
			ack_reg    <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			wake_reg   <= wake_next;
			mask_reg   <= mask_next;
			flag_reg   <= flag_next;
			gie_reg    <= gie_next;
			mode_reg   <= mode_next;
			vec_reg    <= vec_next;
			wake_p_reg <= wake_p_next;
			vreq_reg   <= vreq_next;
			next_reg   <= next_next;
			rst_reg    <= rst_next;
			wclr_reg   <= wclr_next;
			rd_reg     <= rd_next;
			ack_reg    <= ack_next;
		end
	end

	// clock and timer gating per mode
	assign osc_run        = (mode_reg != wkm_pkg::WKM_SLEEP) || adc_busy;
	assign timers_run     = (mode_reg != wkm_pkg::WKM_SLEEP) || adc_busy;
	assign slow_clock_run = osc_run;
	assign main_clock_run = osc_run;

	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign avs_readdata    = rd_reg;
	assign wdt_clear       = wclr_reg;
	assign core_wake       = wake_p_reg;
	assign core_vector_req = vreq_reg;
	assign core_vector     = vec_reg;
	assign core_next_instr = next_reg;
	assign device_reset    = rst_reg;
	assign irq             = |pend_irq;

	// timer events never wake sleep
	a_sleep_no_timer: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(mode_reg == wkm_pkg::WKM_SLEEP && event_in[NEV-1:3] != '0 &&
		event_in[2:0] == '0 && !wdt_timeout) |=> !core_wake)
		else $error("timer woke sleep");
	// port without wake enable never wakes
	a_port_no_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(asleep && !wake_reg[`WKM_WAKE_PORT] && event_in == 9'h001)
		|=> !core_wake)
		else $error("port woke without enable");
	// pending set with irq enable
	a_port_pend: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(event_in[0] && mask_reg[0]) |=> flag_reg[0])
		else $error("port pending not set");
	// port with wake enable wakes
	a_port_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(asleep && wake_reg[`WKM_WAKE_PORT] && event_in[0] && !wdt_timeout)
		|=> core_wake)
		else $error("port failed to wake");
	// no wake pulse in run modes
	a_run_no_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
		run_mode |=> !core_wake)
		else $error("wake pulse in run mode");
	// sleep halts timers unless converting
	a_sleep_halt: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(mode_reg == wkm_pkg::WKM_SLEEP && !adc_busy) |-> !timers_run)
		else $error("timers run in sleep");
	// idle keeps timers running
	a_idle_run: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(mode_reg == wkm_pkg::WKM_IDLE) |-> timers_run)
		else $error("timers stopped in idle");
	// watchdog reset
	a_wdt_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(wdt_timeout && ctrl_reg[`WKM_CTRL_WDT_EN]) |=> device_reset)
		else $error("watchdog did not reset");
	// low voltage reset in run
	a_lvr_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(lowvolt_reset && run_mode) |=> device_reset)
		else $error("low voltage did not reset");
	// vector for port change
	a_port_vec: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(vreq_reg) && flag_reg[0] && mask_reg[0] |->
		core_vector == `WKM_VEC_PORT)
		else $error("wrong port vector");
	// port change with irq enable low sets no flag
	a_port_no_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(event_in[0] && !mask_reg[0] && !flag_reg[0]) |=> !flag_reg[0])
		else $error("port flagged with irq enable low");
	// adc done with its wake enable wakes sleep or idle
	a_adc_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(asleep && wake_reg[`WKM_WAKE_ADC] && event_in[`WKM_EV_ADC])
		|=> core_wake)
		else $error("adc done failed to wake");
	// low voltage without its wake enable never wakes
	a_lvd_no_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(asleep && !wake_reg[`WKM_WAKE_LVD] && event_in == 9'h004)
		|=> !core_wake)
		else $error("low voltage woke without enable");
	// timer events wake idle
	a_idle_timer: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(mode_reg == wkm_pkg::WKM_IDLE && event_in[NEV-1:3] != '0)
		|=> core_wake)
		else $error("timer failed to wake idle");
	// wake with global irq off resumes at the next instruction
	a_wake_next: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(asleep && !gie_reg && |(event_in & wake_ok) && !wdt_timeout)
		|=> core_next_instr)
		else $error("wake without next instruction");
endmodule
`default_nettype wire

// ===== wkm_defines.svh
// constants and register map of the wake-up and interrupt mode controller
// Summary of operation
// - wake only from sleep or idle modes
// - after wake vector if enabled, else next
// - port change wake disabled means no wake
// - wake off, irq on: set pending only
// - wake on, irq off: wake, next instruction
// - idle keeps timers and pulse generator running
// - no port irq in run with enable low
// - adc done wakes if enabled; clocks run
// - timer events wake idle only, never sleep
// - sleep stops oscillator, timers; clears watchdog
// - low voltage wakes only with its enable
// - enabled watchdog timeout resets the device
// - vectors 06, 0C, 21 for wake sources
`ifndef WKM_DEFINES_SVH
`define WKM_DEFINES_SVH
`define WKM_ADDR_CTRL     4'h0
`define WKM_ADDR_WAKE     4'h1
`define WKM_ADDR_MASK     4'h2
`define WKM_ADDR_FLAG     4'h3
`define WKM_ADDR_STATE    4'h4
`define WKM_ADDR_VECTOR   4'h5
`define WKM_ADDR_CMD      4'h6
`define WKM_CTRL_IDLE     0
`define WKM_CTRL_GREEN    1
`define WKM_CTRL_WDT_EN   2
`define WKM_WAKE_PORT     1
`define WKM_WAKE_ADC      3
`define WKM_WAKE_LVD      2
`define WKM_CMD_SLEEP     0
`define WKM_CMD_GIE_ON    1
`define WKM_CMD_GIE_OFF   2
`define WKM_EV_PORT       0
`define WKM_EV_ADC        1
`define WKM_EV_LVD        2
`define WKM_EV_MAIN_TMR   3
`define WKM_EV_AUX_A      4
`define WKM_EV_AUX_B      5
`define WKM_EV_AUX_C      6
`define WKM_EV_PW_HI      7
`define WKM_EV_PW_LO      8
`define WKM_NUM_EV        9
`define WKM_VEC_PORT      8'h06
`define WKM_VEC_ADC       8'h0C
`define WKM_VEC_LVD       8'h21
`define WKM_VEC_TIMER     8'h09
`define WKM_RESET_VAL     32'h0000_0000
`endif

// ===== wkm_pkg.sv
// types of the wake-up and interrupt mode controller
`default_nettype none
package wkm_pkg;
	typedef enum logic [1:0] {
		WKM_NORMAL, WKM_GREEN, WKM_IDLE, WKM_SLEEP
	} wkm_mode_type;
endpackage
`default_nettype wire

// ===== wkm_prio.sv
// fixed priority picker of the lowest pending event index
`timescale 1ns/1ps
`default_nettype none
module wkm_prio #(
	parameter int N = 9
) (
	input  wire logic [N-1:0] req,
	output logic      [3:0]   idx,
	output logic              any
);
	initial begin
		if (N < 1 || N > 16) $error("wkm_prio: N out of range");
	end
	// lowest index wins
	always_comb begin
		idx = 4'h0;
		any = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i);
				any = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
